// File: src/afs_fault_status.sv
// Fault and status aggregation for an eight-channel analog input, APB slave
//
// Summary of operation
// - Summary flags in upper byte of module word
// - Group flag set when any channel fault set
// - Calibrating flag set while any channel calibrates
// - Calibration forces all used channel faults high
// - Calibration patterns 00ff, 000f, 0003 by wiring
// - Lost owner link shows ffff in channel word
// - Calibration error flag from any channel error
// - Calibration error flag sits at bit 9
// - Status word carries only range indications
// - Bad calibration still raises calibration error flag
// - One 32-bit status word for eight channels
// - Underrange of channel n at bit 31-2n
// - Overrange of channel n at bit 30-2n
// - Underrange when input at or below minimum
// - Overrange when input at or above maximum
// - Either range bit raises fault bit of a used channel
// - Channel faults from bit 0, 8/4/2 used
// - Group flag bit 15, calibrating flag bit 10
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps

module afs_fault_status #(
  parameter int N_CH = afs_pkg::AFS_NUM_CH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [afs_pkg::AFS_ADDR_W-1:0] paddr,
  input wire logic [afs_pkg::AFS_DATA_W-1:0] pwdata,
  output logic [afs_pkg::AFS_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_CH-1:0] chan_below_min,
  input wire logic [N_CH-1:0] chan_above_max,
  input wire logic [N_CH-1:0] chan_calibrating,
  input wire logic [N_CH-1:0] chan_cal_bad,
  input wire logic owner_link_lost,
  output logic irq
);
  import afs_pkg::*;

  typedef struct packed {
    afs_apb_e apb;
    logic pready;
    logic pslverr;
    logic [AFS_DATA_W-1:0] prdata;
    logic [N_CH-1:0] below_s1;
    logic [N_CH-1:0] below_s2;
    logic [N_CH-1:0] above_s1;
    logic [N_CH-1:0] above_s2;
    logic [N_CH-1:0] calact_s1;
    logic [N_CH-1:0] calact_s2;
    logic [N_CH-1:0] calbad_s1;
    logic [N_CH-1:0] calbad_s2;
    logic link_s1;
    logic link_s2;
    logic link_seen;
    logic [1:0] wiring;
    logic [AFS_WORD_W-1:0] mod_fault;
    logic [AFS_WORD_W-1:0] chan_fault;
    logic [AFS_STS_W-1:0] range_sts;
    logic [AFS_IRQ_W-1:0] irq_sts;
    logic [AFS_IRQ_W-1:0] irq_en;
    logic irq;
  } afs_state_s;

  afs_state_s q;
  afs_state_s d;

  // Read mux over the current register contents
  function automatic logic [AFS_DATA_W-1:0] afs_read(
    input afs_state_s s,
    input logic [AFS_ADDR_W-1:0] a
  );
    afs_read = '0;
    case (a)
      AFS_OFS_MOD_FAULT: afs_read = {AFS_WORD_ZERO, s.mod_fault};
      AFS_OFS_CHAN_FAULT: afs_read = {AFS_WORD_ZERO, s.chan_fault};
      AFS_OFS_RANGE_STS: afs_read = s.range_sts;
      AFS_OFS_CONFIG: afs_read[1:0] = s.wiring;
      AFS_OFS_IRQ_STS: afs_read[AFS_IRQ_W-1:0] = s.irq_sts;
      AFS_OFS_IRQ_EN: afs_read[AFS_IRQ_W-1:0] = s.irq_en;
      default: afs_read = '0;
    endcase
  endfunction : afs_read

  function automatic logic afs_mapped(input logic [AFS_ADDR_W-1:0] a);
    case (a)
      AFS_OFS_MOD_FAULT,
      AFS_OFS_CHAN_FAULT,
      AFS_OFS_RANGE_STS,
      AFS_OFS_CONFIG,
      AFS_OFS_IRQ_STS,
      AFS_OFS_IRQ_CLR,
      AFS_OFS_IRQ_EN: afs_mapped = 1'b1;
      default: afs_mapped = 1'b0;
    endcase
  endfunction : afs_mapped

  always_comb begin
    logic [AFS_WORD_W-1:0] raw_fault;
    logic [AFS_WORD_W-1:0] used;
    logic [AFS_IRQ_W-1:0] ev;
    logic [AFS_IRQ_W-1:0] clr;
    raw_fault = AFS_WORD_ZERO;
    used = afs_used_mask(q.wiring);
    ev = '0;
    clr = '0;
    d = q;

    // Two-stage synchronisers for the front-end and link levels
    d.below_s1 = chan_below_min;
    d.below_s2 = q.below_s1;
    d.above_s1 = chan_above_max;
    d.above_s2 = q.above_s1;
    d.calact_s1 = chan_calibrating;
    d.calact_s2 = q.calact_s1;
    d.calbad_s1 = chan_cal_bad;
    d.calbad_s2 = q.calbad_s1;
    d.link_s1 = owner_link_lost;
    d.link_s2 = q.link_s1;
    d.link_seen = q.link_s2;

    // Range status word, rebuilt every cycle, only range bits carried
    d.range_sts = '0;
    for (int n = 0; n < N_CH; n++) begin
      d.range_sts[AFS_UNDER_TOP - 2*n] = q.below_s2[n];
      d.range_sts[AFS_OVER_TOP - 2*n] = q.above_s2[n];
      raw_fault[n] = q.below_s2[n] | q.above_s2[n];
    end

    // Channel fault word: link loss beats calibration beats range faults
    if (q.link_s2) begin
      d.chan_fault = AFS_ALL_ONES;
    end else if (|q.calact_s2) begin
      d.chan_fault = used;
    end else begin
      d.chan_fault = raw_fault & used;
    end

    // Module fault word, low byte and spare bits stay clear
    d.mod_fault = AFS_WORD_ZERO;
    d.mod_fault[AFS_MF_GROUP_BIT] = |d.chan_fault;
    d.mod_fault[AFS_MF_CAL_RUN_BIT] = |q.calact_s2;
    d.mod_fault[AFS_MF_CAL_ERR_BIT] = |q.calbad_s2;

    // Events for the interrupt status: flag and link rises, range status on any change
    ev[AFS_EV_GROUP] = d.mod_fault[AFS_MF_GROUP_BIT] &
                       ~q.mod_fault[AFS_MF_GROUP_BIT];
    ev[AFS_EV_CAL_RUN] = d.mod_fault[AFS_MF_CAL_RUN_BIT] &
                         ~q.mod_fault[AFS_MF_CAL_RUN_BIT];
    ev[AFS_EV_CAL_ERR] = d.mod_fault[AFS_MF_CAL_ERR_BIT] &
                         ~q.mod_fault[AFS_MF_CAL_ERR_BIT];
    ev[AFS_EV_LINK] = q.link_s2 & ~q.link_seen;
    ev[AFS_EV_RANGE] = d.range_sts != q.range_sts;

    // APB slave: one wait state, write lands on the completing edge
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    case (q.apb)
      AFS_APB_IDLE: begin
        if (psel && penable) begin
          d.pready = 1'b1;
          d.pslverr = ~afs_mapped(paddr);
          d.prdata = pwrite ? '0 : afs_read(q, paddr);
          d.apb = AFS_APB_RESP;
        end
      end
      AFS_APB_RESP: begin
        if (psel && penable && pwrite && !q.pslverr) begin
          case (paddr)
            AFS_OFS_CONFIG: d.wiring = pwdata[1:0];
            AFS_OFS_IRQ_CLR: clr = pwdata[AFS_IRQ_W-1:0];
            AFS_OFS_IRQ_EN: d.irq_en = pwdata[AFS_IRQ_W-1:0];
            default: clr = '0;
          endcase
        end
        d.apb = AFS_APB_IDLE;
      end
      default: d.apb = AFS_APB_IDLE;
    endcase

    // A new event in the clearing cycle keeps its bit set
    d.irq_sts = (q.irq_sts & ~clr) | ev;
    d.irq = |(d.irq_sts & d.irq_en);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;

  default clocking afs_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  upper_byte_a: assert property (
    (q.mod_fault & AFS_MF_UNUSED) == AFS_WORD_ZERO)
    else $error("module fault word has bits outside the flags");

  group_fault_a: assert property (
    q.mod_fault[AFS_MF_GROUP_BIT] == (|q.chan_fault))
    else $error("group flag disagrees with channel fault word");

  cal_flag_a: assert property (
    (|chan_calibrating) [*3] |=> q.mod_fault[AFS_MF_CAL_RUN_BIT])
    else $error("calibrating flag missing while a channel calibrates");

  cal_force_a: assert property (
    (|q.calact_s2 && !q.link_s2) |=>
      ((q.chan_fault & afs_used_mask($past(q.wiring))) ==
       afs_used_mask($past(q.wiring))))
    else $error("used channel fault bits not forced during calibration");

  cal_pattern_a: assert property (
    (|q.calact_s2 && !q.link_s2 && q.wiring == AFS_WIRE_DIFF) |=>
      (q.chan_fault == AFS_CAL_DIFF))
    else $error("differential calibration pattern wrong");

  link_lost_a: assert property (
    owner_link_lost [*3] |=> (q.chan_fault == AFS_ALL_ONES))
    else $error("channel fault word not all ones on link loss");

  cal_error_a: assert property (
    $rose(q.calbad_s2 != '0) |=> $rose(q.mod_fault[AFS_MF_CAL_ERR_BIT]))
    else $error("calibration error flag did not follow channel error");

  cal_bad_int_a: assert property (
    (chan_cal_bad != '0) [*3] |=> q.mod_fault[AFS_MF_CAL_ERR_BIT])
    else $error("bad calibration did not raise the error flag");

  under_map_a: assert property (
    q.below_s2[0] |=> q.range_sts[AFS_UNDER_TOP])
    else $error("channel 0 underrange not at the top status bit");

  over_map_a: assert property (
    q.above_s2[N_CH-1] |=> q.range_sts[AFS_OVER_TOP - 2*(N_CH-1)])
    else $error("last channel overrange at wrong status bit");

  range_fault_a: assert property (
    (q.below_s2[1] && !q.link_s2 && !(|q.calact_s2)) |=> q.chan_fault[1])
    else $error("underrange did not set the channel fault bit");

  fault_clear_a: assert property (
    (!(|q.below_s2) && !(|q.above_s2) && !(|q.calact_s2) && !q.link_s2)
      |=> (q.chan_fault == AFS_WORD_ZERO &&
           !q.mod_fault[AFS_MF_GROUP_BIT]))
    else $error("faults linger after their cause has gone");

  irq_level_a: assert property (
    q.irq == (|(q.irq_sts & q.irq_en)))
    else $error("interrupt output disagrees with enabled status");

  bus_answer_a: assert property (
    (psel && penable && !pready) |=> pready)
    else $error("slave did not answer one cycle into the access phase");

  // Further checks on the words, the events and the bus
  cal_se_pat_a: assert property (
    (|q.calact_s2 && !q.link_s2 && q.wiring == AFS_WIRE_SE) |=>
      (q.chan_fault == AFS_CAL_SE))
    else $error("single-ended calibration pattern wrong");

  cal_hs_pat_a: assert property (
    (|q.calact_s2 && !q.link_s2 && q.wiring == AFS_WIRE_HSDIFF) |=>
      (q.chan_fault == AFS_CAL_HSDIFF))
    else $error("high-speed calibration pattern wrong");

  cal_run_flag_a: assert property (
    (q.calact_s2 != '0) |=> q.mod_fault[AFS_MF_CAL_RUN_BIT])
    else $error("calibrating flag missing behind the synchroniser");

  cal_run_clear_a: assert property (
    (q.calact_s2 == '0) |=> !q.mod_fault[AFS_MF_CAL_RUN_BIT])
    else $error("calibrating flag stays after calibration ends");

  cal_err_clear_a: assert property (
    (q.calbad_s2 == '0) |=> !q.mod_fault[AFS_MF_CAL_ERR_BIT])
    else $error("calibration error flag without a bad channel");

  link_prio_a: assert property (
    q.link_s2 |=> (q.chan_fault == AFS_ALL_ONES))
    else $error("link loss did not override the channel fault word");

  unused_chan_a: assert property (
    !q.link_s2 |=>
      ((q.chan_fault & ~afs_used_mask($past(q.wiring))) == AFS_WORD_ZERO))
    else $error("unused channel shows a fault bit");

  range_low_a: assert property (
    q.range_sts[AFS_WORD_W-1:0] == AFS_WORD_ZERO)
    else $error("range status carries bits below the range fields");

  under_last_a: assert property (
    q.below_s2[N_CH-1] |=> q.range_sts[AFS_UNDER_TOP - 2*(N_CH-1)])
    else $error("last channel underrange at wrong status bit");

  over_first_a: assert property (
    q.above_s2[0] |=> q.range_sts[AFS_OVER_TOP])
    else $error("channel 0 overrange not at its status bit");

  under_clear_a: assert property (
    !q.below_s2[0] |=> !q.range_sts[AFS_UNDER_TOP])
    else $error("underrange bit stays after the input recovers");

  over_clear_a: assert property (
    !q.above_s2[0] |=> !q.range_sts[AFS_OVER_TOP])
    else $error("overrange bit stays after the input recovers");

  over_fault_a: assert property (
    (q.above_s2[0] && !q.link_s2 && !(|q.calact_s2)) |=> q.chan_fault[0])
    else $error("overrange did not set the channel fault bit");

  below_path_a: assert property (
    chan_below_min[0] |-> ##3 q.range_sts[AFS_UNDER_TOP])
    else $error("underrange input did not reach the status word");

  above_path_a: assert property (
    chan_above_max[0] |-> ##3 q.range_sts[AFS_OVER_TOP])
    else $error("overrange input did not reach the status word");

  group_event_a: assert property (
    $rose(q.mod_fault[AFS_MF_GROUP_BIT]) |-> q.irq_sts[AFS_EV_GROUP])
    else $error("group fault rise not recorded in interrupt status");

  cal_run_event_a: assert property (
    $rose(q.mod_fault[AFS_MF_CAL_RUN_BIT]) |-> q.irq_sts[AFS_EV_CAL_RUN])
    else $error("calibration start not recorded in interrupt status");

  cal_err_event_a: assert property (
    $rose(q.mod_fault[AFS_MF_CAL_ERR_BIT]) |-> q.irq_sts[AFS_EV_CAL_ERR])
    else $error("calibration error not recorded in interrupt status");

  link_event_a: assert property (
    $rose(q.link_s2) |=> q.irq_sts[AFS_EV_LINK])
    else $error("link loss not recorded in interrupt status");

  range_event_a: assert property (
    (q.range_sts != $past(q.range_sts)) |-> q.irq_sts[AFS_EV_RANGE])
    else $error("range change not recorded in interrupt status");

  sticky_sts_a: assert property (
    !(q.apb == AFS_APB_RESP && pwrite && paddr == AFS_OFS_IRQ_CLR) |=>
      ((q.irq_sts & $past(q.irq_sts)) == $past(q.irq_sts)))
    else $error("interrupt status bit dropped without a clear");

  irq_quiet_a: assert property (
    (q.irq_sts == '0) |-> !irq)
    else $error("interrupt raised with no status bit set");

  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("ready held for more than one cycle");

  err_ready_a: assert property (
    pslverr |-> pready)
    else $error("error response without ready");

  err_decode_a: assert property (
    (psel && penable && q.apb == AFS_APB_IDLE) |=>
      (pslverr == !afs_mapped($past(paddr))))
    else $error("error response disagrees with the address map");

  idle_quiet_a: assert property (
    !psel |=> !pready)
    else $error("ready raised without a selected transfer");

endmodule : afs_fault_status

// File: src/afs_pkg.sv
// Constants and types shared by the analog input fault and status block
package afs_pkg;

  // Bus geometry
  localparam int AFS_ADDR_W = 8;
  localparam int AFS_DATA_W = 32;

  // Channel and word geometry
  localparam int AFS_NUM_CH = 8;
  localparam int AFS_WORD_W = 16;
  localparam int AFS_STS_W = 32;
  localparam int AFS_UNDER_TOP = 31;
  localparam int AFS_OVER_TOP = 30;

  // Module fault word bit positions
  localparam int AFS_MF_GROUP_BIT = 15;
  localparam int AFS_MF_CAL_RUN_BIT = 10;
  localparam int AFS_MF_CAL_ERR_BIT = 9;
  localparam logic [15:0] AFS_MF_UNUSED = 16'h78ff;

  // Wiring configuration codes
  localparam logic [1:0] AFS_WIRE_SE = 2'h0;
  localparam logic [1:0] AFS_WIRE_DIFF = 2'h1;
  localparam logic [1:0] AFS_WIRE_HSDIFF = 2'h2;

  // Channel fault patterns forced during calibration and link loss
  localparam logic [15:0] AFS_CAL_SE = 16'h00ff;
  localparam logic [15:0] AFS_CAL_DIFF = 16'h000f;
  localparam logic [15:0] AFS_CAL_HSDIFF = 16'h0003;
  localparam logic [15:0] AFS_ALL_ONES = 16'hffff;
  localparam logic [15:0] AFS_WORD_ZERO = 16'h0000;

  // Register byte offsets
  localparam logic [7:0] AFS_OFS_MOD_FAULT = 8'h00;
  localparam logic [7:0] AFS_OFS_CHAN_FAULT = 8'h04;
  localparam logic [7:0] AFS_OFS_RANGE_STS = 8'h08;
  localparam logic [7:0] AFS_OFS_CONFIG = 8'h0c;
  localparam logic [7:0] AFS_OFS_IRQ_STS = 8'h10;
  localparam logic [7:0] AFS_OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] AFS_OFS_IRQ_EN = 8'h18;

  // Interrupt event bits
  localparam int AFS_IRQ_W = 5;
  localparam int AFS_EV_GROUP = 0;
  localparam int AFS_EV_CAL_RUN = 1;
  localparam int AFS_EV_CAL_ERR = 2;
  localparam int AFS_EV_LINK = 3;
  localparam int AFS_EV_RANGE = 4;

  // Bus response phase
  typedef enum logic [0:0] {
    AFS_APB_IDLE = 1'b0,
    AFS_APB_RESP = 1'b1
  } afs_apb_e;

  // Channels in use for a wiring code; the calibration pattern equals it
  function automatic logic [15:0] afs_used_mask(input logic [1:0] wiring);
    case (wiring)
      AFS_WIRE_DIFF: afs_used_mask = AFS_CAL_DIFF;
      AFS_WIRE_HSDIFF: afs_used_mask = AFS_CAL_HSDIFF;
      default: afs_used_mask = AFS_CAL_SE;
    endcase
  endfunction : afs_used_mask

endpackage : afs_pkg

// File: test/afs_owner_model.sv
// Owner controller model: APB master that reads and writes the words
`timescale 1ns/1ps
module afs_owner_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [afs_pkg::AFS_ADDR_W-1:0] paddr,
  output logic [afs_pkg::AFS_DATA_W-1:0] pwdata,
  input wire logic [afs_pkg::AFS_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import afs_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // Gap plus one sets idle cycles before the setup phase
  task automatic xfer(input int gap, input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    repeat (gap + 1) @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like a held value
    pwdata <= ~d;
  endtask : xfer
endmodule : afs_owner_model

// File: test/tb_analog_input_fault_status_integer.sv
// Self-checking bench for the analog input fault and status block
`timescale 1ns/1ps
module tb_analog_input_fault_status_integer;
  import afs_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, lnk;
  logic [7:0] paddr, below, above, cal, bad;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lf;
  logic err;
  int n_errors = 0, checks_done = 0, cyc = 0;
  afs_fault_status dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_below_min(below), .chan_above_max(above),
    .chan_calibrating(cal), .chan_cal_bad(bad),
    .owner_link_lost(lnk), .irq(irq));
  afs_owner_model u_own (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // Expected word: 0 module fault, 1 channel fault, 2 range status
  function automatic logic [31:0] expw(input int sel, input logic [1:0] w);
    logic [15:0] m, cf;
    logic [31:0] rs;
    m = (w == 2'h1) ? 16'h000f : (w == 2'h2) ? 16'h0003 : 16'h00ff;
    rs = 32'h0;
    for (int i = 0; i < 8; i++) begin
      rs[31-2*i] = below[i];
      rs[30-2*i] = above[i];
    end
    cf = lnk ? 16'hffff : (|cal) ? m : {8'h00, below | above} & m;
    if (sel == 0) return {16'h0, |cf, 4'h0, |cal, |bad, 9'h0};
    if (sel == 1) return {16'h0, cf};
    return rs;
  endfunction : expw
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rdw(input logic [7:0] a);
    u_own.xfer(lf[1:0], 1'b0, a, 32'h0, rd, err);
  endtask : rdw
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_own.xfer(0, 1'b1, a, d, rd, err);
  endtask : wr
  task automatic drv(input logic [7:0] b, ab, c, k, input logic l);
    @(posedge clk);
    below <= b;
    above <= ab;
    cal <= c;
    bad <= k;
    lnk <= l;
    repeat (5) @(posedge clk);
  endtask : drv
  task automatic words(input logic [1:0] w);
    rdw(AFS_OFS_MOD_FAULT);
    check(rd, expw(0, w));
    rdw(AFS_OFS_CHAN_FAULT);
    check(rd, expw(1, w));
    rdw(AFS_OFS_RANGE_STS);
    check(rd, expw(2, w));
  endtask : words
  task automatic close_out;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    rst = 1'b1;
    {below, above, cal, bad, lnk} = '0;
    lf = 16'd28;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    words(2'h0);
    rdw(AFS_OFS_CONFIG);
    check(rd, 32'h0);
    for (int n = 0; n < 60; n++) begin
      lf = nxt(nxt(lf));
      wr(AFS_OFS_CONFIG, {30'h0, lf[1:0]});
      drv(lf[9:2], 8'(nxt(lf) >> 3), (n % 10 == 9) ? lf[15:8] : 8'h00,
        (lf[0] & lf[5]) ? lf[14:7] : 8'h00, n % 15 == 14);
      words(lf[1:0]);
    end
    wr(AFS_OFS_CHAN_FAULT, 32'hffff);
    check({31'h0, err}, 32'h0);
    words(lf[1:0]);
    for (int k = 0; k < 2; k++) begin
      rdw(k ? 8'h02 : 8'h40);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
    end
    for (int w = 0; w < 4; w++) begin
      wr(AFS_OFS_CONFIG, 32'(w));
      drv(8'hff, 8'h00, w[0] ? 8'h00 : 8'h80, 8'(w), 1'b0);
      words(2'(w));
      rdw(AFS_OFS_CONFIG);
      check(rd, 32'(w));
    end
    rdw(AFS_OFS_IRQ_STS);
    check(rd & 32'h0e, 32'h0e);
    drv(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    wr(AFS_OFS_IRQ_CLR, 32'h1f);
    wr(AFS_OFS_IRQ_EN, 32'h1);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    drv(8'h01, 8'h00, 8'h00, 8'h00, 1'b0);
    check({31'h0, irq}, 32'h1);
    wr(AFS_OFS_IRQ_EN, 32'h0);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdw(AFS_OFS_IRQ_STS);
    check(rd & 32'h11, 32'h11);
    wr(AFS_OFS_IRQ_EN, 32'h1);
    rdw(AFS_OFS_IRQ_EN);
    check(rd, 32'h1);
    drv(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    check({31'h0, irq}, 32'h1);
    wr(AFS_OFS_IRQ_CLR, 32'h1);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdw(AFS_OFS_IRQ_CLR);
    check(rd, 32'h0);
    close_out;
  end
endmodule : tb_analog_input_fault_status_integer
